// ---- core/lcd_pkg.sv ----
// Shared constants, types and decode functions for the LCD display RAM and bank select block.
// Assumes a 32-bit APB slave port at 200 MHz and a 32 x 4-bit display RAM.
package lcd_pkg;

	// Register byte offsets
	localparam logic [7:0] OFS_CTRL    = 8'h00;
	localparam logic [7:0] OFS_POINTER = 8'h04;
	localparam logic [7:0] OFS_SUBADDR = 8'h08;
	localparam logic [7:0] OFS_DATA    = 8'h0c;
	localparam logic [7:0] OFS_STATUS  = 8'h10;
	localparam logic [7:0] OFS_SEGS    = 8'h14;

	// Geometry
	localparam int unsigned COLS     = 32;
	localparam int unsigned ROWS     = 4;
	localparam int unsigned PTR_W    = 5;
	localparam int unsigned BYTE_W   = 8;
	localparam int unsigned CTRL_W   = 9;

	// Field positions in the status word
	localparam int unsigned STAT_ROW_LSB   = 0;
	localparam int unsigned STAT_PINS_LSB  = 2;
	localparam int unsigned STAT_MATCH_BIT = 4;

	// Row where bank 1 starts in static and 1:2 modes
	localparam logic [1:0] BANK1_ROW_BASE = 2'h2;

	// Clock cycles per multiplex step; the real frame timing is outside this block
	localparam int unsigned MUX_STEP_CYCLES = 8;
	localparam logic [3:0]  MUX_STEP_LAST   = 4'(MUX_STEP_CYCLES - 1);

	// Drive modes as written into the control word
	typedef enum logic [1:0] {
		MODE_STATIC = 2'h0,
		MODE_MUX2   = 2'h1,
		MODE_MUX3   = 2'h2,
		MODE_MUX4   = 2'h3
	} drive_mode_t;

	// Control word, most significant field first in the register
	typedef struct packed {
		logic [1:0]  blink_rate_field;
		logic        alternate_bank_blink_bit;
		logic        out_bank;
		logic        in_bank;
		drive_mode_t mode;
		logic        bias_third;
		logic        display_enable;
	} ctrl_t;

	localparam ctrl_t CTRL_RESET = ctrl_t'(9'h000);

	// One write to the RAM: per-bit enable and data, row major
	typedef struct packed {
		logic [ROWS-1:0][COLS-1:0] mask;
		logic [ROWS-1:0][COLS-1:0] data;
	} ram_wr_t;

	// Rows used per column, which is also the multiplex length
	function automatic logic [2:0] rows_per_col(input drive_mode_t m);
		case (m)
			MODE_STATIC: rows_per_col = 3'h1;
			MODE_MUX2:   rows_per_col = 3'h2;
			MODE_MUX3:   rows_per_col = 3'h3;
			default:     rows_per_col = 3'h4;
		endcase
	endfunction

	// Pointer advance after each byte
	function automatic logic [PTR_W-1:0] ptr_step(input drive_mode_t m);
		case (m)
			MODE_STATIC: ptr_step = 5'h08;
			MODE_MUX2:   ptr_step = 5'h04;
			MODE_MUX3:   ptr_step = 5'h03;
			default:     ptr_step = 5'h02;
		endcase
	endfunction

	// Bank switching exists only where two banks fit
	function automatic logic bank_capable(input drive_mode_t m);
		bank_capable = (m == MODE_STATIC) || (m == MODE_MUX2);
	endfunction

endpackage

// ---- core/lcd_display_ram.sv ----
// 32 x 4-bit display RAM with bitwise write enables and one registered row read port.
// Assumes the caller presents a full row-major write mask and data in one cycle.
`timescale 1ns/10ps
module lcd_display_ram (
	input  wire logic                                   pclk,
	input  wire logic                                   presetn,
	input  wire lcd_pkg::ram_wr_t                       wr,
	input  wire logic [1:0]                             rd_row,
	output logic      [lcd_pkg::COLS-1:0]               rd_data
);
	import lcd_pkg::*;

	logic [ROWS-1:0][COLS-1:0] cell_q;
	logic [ROWS-1:0][COLS-1:0] cell_d;
	logic [COLS-1:0]           rd_data_d;
	logic [COLS-1:0]           rd_data_q;

	// Cells have no reset: content is undefined until the host fills it
	for (genvar r = 0; r < ROWS; r++) begin : g_row
		always_comb begin
			cell_d[r] = (cell_q[r] & ~wr.mask[r]) | (wr.data[r] & wr.mask[r]);
		end

		always_ff @(posedge pclk) begin
			cell_q[r] <= cell_d[r];
		end
	end

	// Registered read keeps the segment path a clean flop-to-flop
	always_comb begin
		rd_data_d = cell_q[rd_row];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_data_q <= '0;
		end else begin
			rd_data_q <= rd_data_d;
		end
	end

	assign rd_data = rd_data_q;

endmodule

// ---- core/lcd_display_ram_bank_select.sv ----
// Display RAM write mapping, data pointer, subaddress gate and bank selectors, behind APB.
// Assumes a single APB master on pclk; the multiplex step rate stands in for the frame clock.
`timescale 1ns/10ps
module lcd_display_ram_bank_select (
	input  wire logic                          pclk,
	input  wire logic                          presetn,
	input  wire logic                          psel,
	input  wire logic                          penable,
	input  wire logic                          pwrite,
	input  wire logic [7:0]                    paddr,
	input  wire logic [31:0]                   pwdata,
	output logic      [31:0]                   prdata,
	output logic                               pready,
	output logic                               pslverr,
	input  wire logic                          hw_subaddr_pin_low,
	input  wire logic                          hw_subaddr_pin_high,
	output logic      [lcd_pkg::COLS-1:0]      segment_output,
	output logic      [lcd_pkg::ROWS-1:0]      backplane_output
);
	import lcd_pkg::*;

	// APB answer state
	logic        pready_q, pready_d;
	logic        pslverr_q, pslverr_d;
	logic [31:0] prdata_q, prdata_d;
	logic        access;
	logic        wr_fire;

	// Configuration and addressing state
	ctrl_t            ctrl_q, ctrl_d;
	logic [PTR_W-1:0] ptr_q, ptr_d;
	logic [1:0]       subaddr_q, subaddr_d;
	logic             data_fire;
	logic             match;

	// Write mapping
	ram_wr_t wr;

	// Multiplex sequencing and display path
	logic [3:0]      div_q, div_d;
	logic [1:0]      step_q, step_d;
	logic [1:0]      step_pipe_q, step_pipe_d;
	logic [1:0]      rd_row;
	logic [COLS-1:0] rd_data;
	logic [COLS-1:0] seg_q, seg_d;
	logic [ROWS-1:0] bp_q, bp_d;

	// Register decode that both the answer and the write paths need
	function automatic logic addr_known(input logic [7:0] a);
		addr_known = (a == OFS_CTRL) || (a == OFS_POINTER) || (a == OFS_SUBADDR) ||
			(a == OFS_DATA) || (a == OFS_STATUS) || (a == OFS_SEGS);
	endfunction

	assign access    = psel && penable && pready_q;
	assign wr_fire   = access && pwrite && addr_known(paddr);
	assign data_fire = wr_fire && (paddr == OFS_DATA);
	assign match     = (subaddr_q == {hw_subaddr_pin_high, hw_subaddr_pin_low});

	// APB: answer prepared in setup so ready comes from a flop; zero wait states
	always_comb begin
		pready_d  = psel && !penable;
		pslverr_d = 1'b0;
		prdata_d  = '0;
		if (psel && !penable) begin
			pslverr_d = !addr_known(paddr);
			if (!pwrite) begin
				case (paddr)
					OFS_CTRL:    prdata_d = 32'(ctrl_q);
					OFS_POINTER: prdata_d = 32'(ptr_q);
					OFS_SUBADDR: prdata_d = 32'(subaddr_q);
					OFS_STATUS: begin
						prdata_d[STAT_ROW_LSB +: 2]  = step_q;
						prdata_d[STAT_PINS_LSB +: 2] = {hw_subaddr_pin_high, hw_subaddr_pin_low};
						prdata_d[STAT_MATCH_BIT]     = match;
					end
					OFS_SEGS:    prdata_d = 32'(seg_q);
					default:     prdata_d = '0;
				endcase
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= '0;
		end else begin
			pready_q  <= pready_d;
			pslverr_q <= pslverr_d;
			prdata_q  <= prdata_d;
		end
	end

	// Configuration, pointer and subaddress counter
	always_comb begin
		logic [PTR_W:0] sum;
		sum       = '0;
		ctrl_d    = ctrl_q;
		ptr_d     = ptr_q;
		subaddr_d = subaddr_q;
		if (wr_fire && paddr == OFS_CTRL) begin
			ctrl_d = ctrl_t'(pwdata[CTRL_W-1:0]);
		end
		if (wr_fire && paddr == OFS_POINTER) begin
			ptr_d = pwdata[PTR_W-1:0];
		end
		if (wr_fire && paddr == OFS_SUBADDR) begin
			subaddr_d = pwdata[1:0];
		end
		if (data_fire) begin
			sum   = {1'b0, ptr_q} + {1'b0, ptr_step(ctrl_q.mode)};
			ptr_d = sum[PTR_W-1:0];
			if (sum[PTR_W]) begin
				subaddr_d = subaddr_q + 2'h1;  // Overflow walks on to the next device
			end
		end
	end

	// Config resets to defined values for simulation; software must still set it up
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q    <= CTRL_RESET;
			ptr_q     <= '0;
			subaddr_q <= '0;
		end else begin
			ctrl_q    <= ctrl_d;
			ptr_q     <= ptr_d;
			subaddr_q <= subaddr_d;
		end
	end

	// Byte placement: bit 7 first, filling rows of a column before the next column.
	// A new byte at a used column simply overwrites its rows, which is the rewrite trick.
	always_comb begin
		int         per;
		int         off;
		int         row;
		logic [1:0] base;
		logic [1:0] r;
		logic [4:0] col;
		per  = int'(rows_per_col(ctrl_q.mode));
		off  = 0;
		row  = 0;
		r    = '0;
		col  = '0;
		base = (bank_capable(ctrl_q.mode) && ctrl_q.in_bank) ? BANK1_ROW_BASE : 2'h0;
		wr   = '0;
		for (int i = 0; i < BYTE_W; i++) begin
			off = i / per;
			row = i % per;
			r   = row[1:0] + base;
			col = ptr_q + off[4:0];
			wr.mask[r][col] = data_fire && match;
			wr.data[r][col] = pwdata[BYTE_W-1-i];
		end
	end

	lcd_display_ram u_ram (
		.pclk    (pclk),
		.presetn (presetn),
		.wr      (wr),
		.rd_row  (rd_row),
		.rd_data (rd_data)
	);

	// Multiplex step: backplane index cycles through the rows the mode uses
	always_comb begin
		div_d       = (div_q == MUX_STEP_LAST) ? 4'h0 : div_q + 4'h1;
		step_d      = step_q;
		step_pipe_d = step_q;
		if ({1'b0, step_q} >= rows_per_col(ctrl_q.mode)) begin
			step_d = 2'h0;  // Mode shrank under us; restart the sequence
		end else if (div_q == MUX_STEP_LAST) begin
			step_d = ({1'b0, step_q} == rows_per_col(ctrl_q.mode) - 3'h1) ? 2'h0 :
				step_q + 2'h1;
		end
	end

	// RAM row shown: bank 1 lifts the row by two, only where banks exist
	assign rd_row = step_q + ((bank_capable(ctrl_q.mode) && ctrl_q.out_bank) ?
		BANK1_ROW_BASE : 2'h0);

	// Display register: blank while disabled
	always_comb begin
		seg_d = '0;
		bp_d  = '0;
		if (ctrl_q.display_enable) begin
			seg_d = rd_data;
			bp_d  = ROWS'(1) << step_pipe_q;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_q       <= '0;
			step_q      <= '0;
			step_pipe_q <= '0;
			seg_q       <= '0;
			bp_q        <= '0;
		end else begin
			div_q       <= div_d;
			step_q      <= step_d;
			step_pipe_q <= step_pipe_d;
			seg_q       <= seg_d;
			bp_q        <= bp_d;
		end
	end

	assign prdata           = prdata_q;
	assign pready           = pready_q;
	assign pslverr          = pslverr_q;
	assign segment_output   = seg_q;
	assign backplane_output = bp_q;

	// Checks
	chk_ptr_advance: assert property (@(posedge pclk) disable iff (!presetn)
		data_fire |=> ptr_q == 5'($past(ptr_q) + ptr_step($past(ctrl_q.mode))))
		else $error("pointer did not advance by the mode step");

	chk_store_gated: assert property (@(posedge pclk) disable iff (!presetn)
		(data_fire && !match) |-> (wr.mask == '0))
		else $error("byte stored without subaddress match");

	chk_mux3_col_map: assert property (@(posedge pclk) disable iff (!presetn)
		(data_fire && match && ctrl_q.mode == MODE_MUX3) |->
		(wr.mask[2][ptr_q] && wr.mask[1][5'(ptr_q + 5'h2)] &&
		!wr.mask[2][5'(ptr_q + 5'h2)] && wr.mask[3] == '0 &&
		wr.data[0][5'(ptr_q + 5'h2)] == pwdata[1]))
		else $error("1:3 byte placement wrong");

	chk_in_bank_row: assert property (@(posedge pclk) disable iff (!presetn)
		(data_fire && match && ctrl_q.mode == MODE_STATIC && ctrl_q.in_bank) |->
		(wr.mask[0] == '0 && wr.mask[2][5'(ptr_q + 5'h7)] && wr.data[2][ptr_q] == pwdata[7]))
		else $error("alternate input bank not row 2");

	chk_mux3_no_row3: assert property (@(posedge pclk) disable iff (!presetn)
		(ctrl_q.mode == MODE_MUX3) |-> (rd_row != 2'h3))
		else $error("row 3 shown in 1:3 mode");

	chk_static_row: assert property (@(posedge pclk) disable iff (!presetn)
		(ctrl_q.mode == MODE_STATIC && $stable(ctrl_q) && !ctrl_q.out_bank) |-> (rd_row == 2'h0))
		else $error("static mode not showing row 0");

	chk_bank1_row: assert property (@(posedge pclk) disable iff (!presetn)
		(ctrl_q.mode == MODE_MUX2 && ctrl_q.out_bank && step_q < 2'h2) |->
		(rd_row == step_q + 2'h2))
		else $error("output bank 1 not lifting rows by two");

	chk_mux4_sequence: assert property (@(posedge pclk) disable iff (!presetn)
		(ctrl_q.mode == MODE_MUX4 && div_q == MUX_STEP_LAST && $stable(ctrl_q)) |=>
		(step_q == 2'($past(step_q) + 2'h1)))
		else $error("1:4 sequence out of order");

	chk_blank_display: assert property (@(posedge pclk) disable iff (!presetn)
		(!ctrl_q.display_enable) |=> (segment_output == '0 && backplane_output == '0))
		else $error("display not blank while disabled");

	chk_ctrl_hold: assert property (@(posedge pclk) disable iff (!presetn)
		!(wr_fire && paddr == OFS_CTRL) |=> (ctrl_q == $past(ctrl_q)))
		else $error("configuration changed without a write");

	chk_mux2_sequence: assert property (@(posedge pclk) disable iff (!presetn)
		(ctrl_q.mode == MODE_MUX2 && div_q == MUX_STEP_LAST && step_q < 2'h2) |=>
		(step_q == ($past(step_q) ^ 2'h1)))
		else $error("1:2 sequence out of order");

	chk_mux3_wrap: assert property (@(posedge pclk) disable iff (!presetn)
		(ctrl_q.mode == MODE_MUX3 && div_q == MUX_STEP_LAST && step_q == 2'h2) |=>
		(step_q == 2'h0))
		else $error("1:3 sequence did not return to row 0");

	chk_bp_onehot: assert property (@(posedge pclk) disable iff (!presetn)
		ctrl_q.display_enable |=>
		$onehot(backplane_output))
		else $error("backplane select not one-hot while enabled");

	chk_bank_ignored: assert property (@(posedge pclk) disable iff (!presetn)
		!bank_capable(ctrl_q.mode) |->
		(rd_row == step_q))
		else $error("output bank applied in 1:3 or 1:4 mode");

endmodule

// ---- verification/lcd_host_model.sv ----
// Host side of the register bus: APB master tasks and the bring-up order.
// Assumes every task is entered just after a rising edge of pclk.
`timescale 1ns/10ps
module lcd_host_model (
	input  wire logic        pclk,
	input  wire logic        pready,
	input  wire logic [31:0] prdata,
	input  wire logic        pslverr,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [7:0]       paddr,
	output logic [31:0]      pwdata
);
	import lcd_pkg::*;

	// Bus idle from time zero
	initial begin
		psel    = 1'b0;
		penable = 1'b0;
		pwrite  = 1'b0;
		paddr   = 8'h00;
		pwdata  = 32'h0;
	end

	// One transfer; an idle cycle follows so no signal is driven twice in one step
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] q, output logic e);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// No cycle count assumed: only the bench watchdog ends a stuck wait
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	// Bring-up: mode with display off and banks and blink cleared, pointer, subaddress
	task automatic setup(input drive_mode_t m);
		logic [31:0] q;
		logic        e;
		xfer(1'b1, OFS_STATUS, 32'h0, q, e);
		xfer(1'b1, OFS_CTRL, {28'h0, m, 2'b00}, q, e);
		xfer(1'b1, OFS_POINTER, 32'h0, q, e);
		xfer(1'b1, OFS_SUBADDR, 32'h0, q, e);
	endtask
endmodule

// ---- verification/tb_lcd_display_ram_bank_select.sv ----
// Self-checking bench: host model writes RAM and control, display outputs are judged.
// Assumes the host model tasks are called just after a rising edge of pclk.
`timescale 1ns/10ps
module tb_lcd_display_ram_bank_select;
	import lcd_pkg::*;
	logic        pclk;
	logic        presetn = 1'b0;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        pin_lo  = 1'b0;
	logic        pin_hi  = 1'b0;
	logic [31:0] seg;
	logic [3:0]  bp;
	logic [31:0] sh [4] = '{default: '0};
	logic [31:0] kn [4] = '{default: '0};
	logic [31:0] rdv;
	logic        er;
	logic [4:0]  pt;
	int          err_total = 0;
	int          total_checks = 0;

	lcd_display_ram_bank_select u_dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .hw_subaddr_pin_low(pin_lo), .hw_subaddr_pin_high(pin_hi),
		.segment_output(seg), .backplane_output(bp));

	lcd_host_model u_host (
		.pclk(pclk), .pready(pready), .prdata(prdata), .pslverr(pslverr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

	// 200 MHz clock
	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end

	task automatic close_out();
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
		end
	endtask

	function automatic logic [31:0] cw(input logic en, input drive_mode_t m,
			input logic ib, input logic ob);
		return {26'h0, ob, ib, m, 1'b0, en};
	endfunction

	// Register access helpers
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		u_host.xfer(1'b1, a, d, rdv, er);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		u_host.xfer(1'b0, a, 32'h0, rdv, er);
		chk(rdv, exp);
	endtask

	task automatic setp(input logic [4:0] p);
		wr(OFS_POINTER, {27'h0, p});
		pt = p;
	endtask

	task automatic init(input drive_mode_t m);
		u_host.setup(m);
		pt = 5'h0;
	endtask

	// Byte placement model: bit 7 first, n rows per column from the base row
	task automatic put(input int n, input int base, input logic [7:0] b, input logic st);
		logic [4:0] c;
		for (int i = 0; i < 8 && st; i++) begin
			c = 5'(pt + i / n);
			sh[base + i % n][c] = b[7 - i];
			kn[base + i % n][c] = 1'b1;
		end
		wr(OFS_DATA, {24'h0, b});
		pt = pt + 5'(n == 3 ? 3 : 8 / n);
	endtask

	// Waits for a settled step, then compares only the columns the model knows
	task automatic show(input int step, input int row);
		int cnt;
		cnt = 0;
		for (int n = 0; n < 200 && cnt < 4; n++) begin
			@(negedge pclk);
			cnt = (bp === 4'(1 << step)) ? cnt + 1 : 0;
		end
		chk(32'(cnt), 32'h4);
		chk(seg & kn[row], sh[row] & kn[row]);
		@(posedge pclk);
	endtask

	// Reset values, control word readback, unmapped access, blank display
	task automatic s_regs();
		rd(OFS_STATUS, 32'h10);
		rd(OFS_SEGS, 32'h0);
		rd(OFS_CTRL, 32'h0);
		wr(OFS_CTRL, 32'h1fe);
		rd(OFS_CTRL, 32'h1fe);
		rd(8'h18, 32'h0);
		chk(32'(er), 32'h1);
		chk({28'h0, bp}, 32'h0);
	endtask

	// Static and 1:2: bank 1 written with the display off, bank 0 then shown, then the output bank flips
	task automatic s_bank(input drive_mode_t m, input int n);
		init(m);
		setp(5'h4);
		put(n, 0, 8'hb4, 1'b1);
		rd(OFS_POINTER, 32'(4 + 8 / n));
		wr(OFS_CTRL, cw(1'b0, m, 1'b1, 1'b0));
		setp(5'h4);
		put(n, 2, 8'h2d, 1'b1);
		wr(OFS_CTRL, cw(1'b1, m, 1'b1, 1'b0));
		for (int s = 0; s < n; s++) show(s, s);
		wr(OFS_CTRL, cw(1'b1, m, 1'b0, 1'b1));
		for (int s = 0; s < n; s++) show(s, s + 2);
	endtask

	// 1:3 with pointer reload; bank bits set but without effect in this mode
	task automatic s_mux3();
		int n;
		init(MODE_MUX3);
		wr(OFS_CTRL, cw(1'b1, MODE_MUX3, 1'b1, 1'b1));
		setp(5'h5);
		put(3, 0, 8'h96, 1'b1);
		show(2, 2);
		setp(5'h7);
		put(3, 0, 8'h5b, 1'b1);
		rd(OFS_POINTER, 32'ha);
		for (int s = 0; s < 3; s++) show(s, s);
		n = 0;
		repeat (80) begin
			@(negedge pclk);
			n += (bp[3] === 1'b1) ? 1 : 0;
		end
		@(posedge pclk);
		chk(32'(n), 32'h0);
	endtask

	// 1:4 across the pointer wrap; the stepped subaddress gates the store
	task automatic s_mux4();
		init(MODE_MUX4);
		setp(5'h1e);
		put(4, 0, 8'he7, 1'b1);
		rd(OFS_POINTER, 32'h0);
		rd(OFS_SUBADDR, 32'h1);
		setp(5'h4);
		put(4, 0, 8'h18, 1'b0);
		rd(OFS_POINTER, 32'h6);
		pin_lo <= 1'b1;
		put(4, 0, 8'h3c, 1'b1);
		wr(OFS_CTRL, cw(1'b1, MODE_MUX4, 1'b0, 1'b0));
		for (int s = 0; s < 4; s++) show(s, s);
		wr(OFS_CTRL, cw(1'b0, MODE_MUX4, 1'b0, 1'b0));
		repeat (4) @(posedge pclk);
		chk(seg, 32'h0);
		chk({28'h0, bp}, 32'h0);
		pin_lo <= 1'b0;
	endtask

	// Main sequence
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		s_regs();
		s_bank(MODE_STATIC, 1);
		s_bank(MODE_MUX2, 2);
		s_mux3();
		s_mux4();
		close_out();
	end

	// Watchdog at 10000 cycles, well beyond the expected run of under a thousand cycles
	initial begin
		#50000;
		err_total++;
		close_out();
	end
endmodule
